// ### src/uhtrc_pkg.sv
// Summary of operation
// - High reset idles device; hold six clocks (bench holds four)
// - Select and strobes pick data, status, control
// - Deselected: bus floats, strobes ignored
// - Separate byte registers; transmit double buffered, receive through a four-deep queue
// - Inverted modem input readable in status
// - Terminal ready output low when command bit set
// - Request output low when command bit set
// - Transmit only with enable set and clear-to-send low
// - Disable waits until written characters are sent
// - Shift serial output on bit clock fall
// - Line marks after reset, when off, or when empty in async mode
// - Ready pin masked by disable, cleared on write
// - Ready status bit shows holding register only
// - Empty pin high when nothing left, ignores enable
// - Empty stays high while sync fillers go out
// - Bit rate is clock over 1, 16 or 64
// - Receiver samples on bit clock rise
// - Async receiver needs one high after reset
// - Start edge confirmed low at bit centre in 16x and 64x modes
// - Parity mismatch sets parity error status
// - Missing stop bit sets framing error status
// - Receiver ready shows a waiting character
// - Data read clears receiver ready unless the queue holds another character
// - First control write is mode, later are commands
// - Async frame: start, data lsb first, parity, stops
package uhtrc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int RESET_MIN_CYC = 6;
  localparam int MIN_CLK_PER_BIT = 30;
  localparam logic [1:0] F_SYNC = 2'h0;
  localparam logic [1:0] F_16X = 2'h2;
  localparam logic [1:0] F_64X = 2'h3;
  localparam logic [5:0] DIV1_MAX = 6'h00;
  localparam logic [5:0] DIV16_MAX = 6'h0F;
  localparam logic [5:0] DIV64_MAX = 6'h3F;
  localparam logic [3:0] BASE_LEN = 4'h5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] SYNC_FILL = 8'h16;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;

  typedef struct packed {
    logic [1:0] stop;
    logic even;
    logic par_en;
    logic [1:0] len;
    logic [1:0] factor;
  } uhtrc_mode_t;

  typedef struct packed {
    logic hunt;
    logic ireset;
    logic rts;
    logic err_rst;
    logic sbrk;
    logic rx_en;
    logic dtr;
    logic tx_en;
  } uhtrc_cmd_t;

  typedef struct packed {
    logic dsr;
    logic syndet;
    logic fe;
    logic oe;
    logic pe;
    logic tx_empty_flag;
    logic rx_ready;
    logic tx_ready;
  } uhtrc_stat_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [11:0] bits;
  } uhtrc_frame_t;

  typedef enum logic [1:0] {RX_WAIT1, RX_HUNT, RX_START, RX_BITS} uhtrc_rx_st_t;
endpackage : uhtrc_pkg

// ### src/uhtrc_core.sv
`timescale 1ns/1ns
module uhtrc_fifo
  import uhtrc_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  input logic clk,
  input logic reset,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] wp_next = (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
  wire [AW-1:0] rp_next = (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
  assign in_ready = cnt_reg != (AW + 1)'(D);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rp_reg];

  for (genvar g = 0; g < D; g++) begin : g_mem
    always_ff @(posedge clk) begin
      if (push && wp_reg == AW'(g)) begin
        mem_reg[g] <= in_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= push ? wp_next : wp_reg;
      rp_reg <= pop ? rp_next : rp_reg;
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : uhtrc_fifo

module uhtrc_core
  import uhtrc_pkg::*;
(
  input logic clk,
  input logic reset,
  input logic cs_n,
  input logic rd_n,
  input logic wr_n,
  input logic c_d,
  input logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input logic tx_bit_clock,
  input logic rx_bit_clock,
  output logic txd,
  input logic rxd,
  input logic cts_n,
  input logic dsr_n,
  output logic dtr_n,
  output logic rts_n,
  output logic tx_ready,
  output logic rx_ready,
  output logic tx_empty_a
);
  uhtrc_mode_t mode_reg;
  uhtrc_cmd_t cmd_reg;
  logic mode_set_reg;
  logic wr_prev_reg;
  logic rd_prev_reg;
  logic txc_prev_reg;
  logic rxc_prev_reg;
  logic [7:0] data_out_reg;
  logic data_oe_n_reg;
  logic dtr_n_reg;
  logic rts_n_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Bus decode; a deselected part never sees a strobe edge
  wire sel = ~cs_n;
  wire wr_act = sel & ~wr_n;
  wire rd_act = sel & ~rd_n & wr_n;
  wire wr_lead = wr_act & ~wr_prev_reg;
  wire rd_lead = rd_act & ~rd_prev_reg;
  wire data_wr = wr_lead & ~c_d;
  wire ctrl_wr = wr_lead & c_d;
  wire data_rd = rd_lead & ~c_d;
  wire uhtrc_cmd_t cmd_in = uhtrc_cmd_t'(data_in);
  wire cmd_wr = ctrl_wr & mode_set_reg;
  wire soft_rst = cmd_wr & cmd_in.ireset;
  wire err_clr = cmd_wr & cmd_in.err_rst;
  wire rst_all = reset | soft_rst;
  wire uhtrc_mode_t mode_next = (ctrl_wr & ~mode_set_reg) ? uhtrc_mode_t'(data_in) : mode_reg;
  wire uhtrc_cmd_t cmd_next = cmd_wr ? cmd_in : cmd_reg;
  wire async_m = mode_reg.factor != F_SYNC;
  wire [5:0] div_max = (mode_reg.factor == F_16X) ? DIV16_MAX :
                       (mode_reg.factor == F_64X) ? DIV64_MAX : DIV1_MAX;
  wire [3:0] nd = BASE_LEN + {2'h0, mode_reg.len};

  // Strobe history survives a soft reset so the same write is not retaken
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      txc_prev_reg <= 1'b1;
      rxc_prev_reg <= 1'b1;
    end else begin
      wr_prev_reg <= wr_act;
      rd_prev_reg <= rd_act;
      txc_prev_reg <= tx_bit_clock;
      rxc_prev_reg <= rx_bit_clock;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      mode_reg <= MODE_RST;
      cmd_reg <= CMD_RST;
      mode_set_reg <= 1'b0;
      dtr_n_reg <= 1'b1;
      rts_n_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      cmd_reg <= cmd_next;
      mode_set_reg <= mode_set_reg | ctrl_wr;
      dtr_n_reg <= ~cmd_next.dtr;
      rts_n_reg <= ~cmd_next.rts;
    end
  end

  a_dtr_follow: assert property ($rose(cmd_reg.dtr) |-> !dtr_n)
    else $error("terminal ready not low after command");
  a_rts_follow: assert property ($rose(cmd_reg.rts) |-> !rts_n)
    else $error("request to send not low after command");

  function automatic uhtrc_frame_t build_frame(input logic [7:0] ch, input uhtrc_mode_t m);
    uhtrc_frame_t f;
    logic [3:0] n;
    logic p;
    logic am;
    int i;
    f.bits = 12'hFFF;
    n = 4'h0;
    p = ~m.even;
    am = m.factor != F_SYNC;
    if (am) begin
      f.bits[0] = 1'b0;
      n = 4'h1;
    end
    for (i = 0; i < 8; i++) begin
      if (i < 5 + int'(m.len)) begin
        f.bits[n] = ch[i];
        p = p ^ ch[i];
        n = n + 4'h1;
      end
    end
    if (m.par_en) begin
      f.bits[n] = p;
      n = n + 4'h1;
    end
    // One and a half stop bits are stretched to two
    if (am) begin
      n = n + 4'h1 + {3'h0, m.stop[1]};
    end
    f.cnt = n;
    return f;
  endfunction : build_frame

  // Transmitter
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic hold_ok_reg;
  logic tx_act_reg;
  logic tx_fill_reg;
  logic [11:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [5:0] tx_div_reg;
  logic line_reg;
  logic txd_reg;
  logic tx_ready_reg;
  logic tx_empty_reg;

  wire txc_fall = txc_prev_reg & ~tx_bit_clock;
  wire tx_tick = txc_fall & (tx_div_reg == div_max);
  wire tx_allowed = cmd_reg.tx_en & ~cts_n;
  wire tx_idle = tx_left_reg == 4'h0;
  wire tx_load = tx_tick & tx_idle & hold_full_reg & (tx_allowed | hold_ok_reg);
  wire tx_filler = tx_tick & tx_idle & ~tx_load & ~async_m & tx_allowed;
  wire tx_start = tx_load | tx_filler;
  wire tx_done = tx_tick & tx_idle & ~tx_start;
  wire uhtrc_frame_t frame = build_frame(tx_load ? hold_reg : SYNC_FILL, mode_reg);
  wire hold_full_next = data_wr | (hold_full_reg & ~tx_load);
  // A character accepted while enabled stays owed after a disable
  wire hold_ok_next = hold_full_next & (tx_allowed | (hold_ok_reg & ~tx_load));
  wire tx_act_next = tx_start | (tx_act_reg & ~tx_done);
  wire tx_fill_next = tx_start ? tx_filler : tx_fill_reg;
  wire line_next = tx_start ? frame.bits[0] :
                   (tx_tick & ~tx_idle) ? tx_sh_reg[0] : (tx_done | line_reg);
  wire [5:0] tx_div_next = ~txc_fall ? tx_div_reg : tx_tick ? 6'h00 : tx_div_reg + 6'h01;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      hold_full_reg <= 1'b0;
      hold_ok_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      tx_fill_reg <= 1'b0;
      tx_left_reg <= 4'h0;
      tx_div_reg <= 6'h00;
      line_reg <= 1'b1;
      txd_reg <= 1'b1;
      tx_ready_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
    end else begin
      hold_full_reg <= hold_full_next;
      hold_ok_reg <= hold_ok_next;
      tx_act_reg <= tx_act_next;
      tx_fill_reg <= tx_fill_next;
      tx_div_reg <= tx_div_next;
      line_reg <= line_next;
      txd_reg <= line_next & ~cmd_next.sbrk;
      tx_ready_reg <= ~hold_full_next & tx_allowed;
      tx_empty_reg <= ~hold_full_next & (~tx_act_next | tx_fill_next);
      if (tx_start) begin
        tx_sh_reg <= {1'b1, frame.bits[11:1]};
        tx_left_reg <= frame.cnt - 4'h1;
      end else if (tx_tick & ~tx_idle) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (data_wr) begin
      hold_reg <= data_in;
    end
  end

  a_tx_gate: assert property ($rose(tx_act_reg) && !tx_fill_reg |->
      $past(tx_allowed) || $past(hold_ok_reg))
    else $error("character started while transmitter blocked");
  a_start_low: assert property (tx_load && async_m && !soft_rst |=> !txd)
    else $error("async character did not open with a low start bit");
  a_mark_idle: assert property (!tx_act_reg && !cmd_reg.sbrk |-> txd)
    else $error("line not marking while transmitter idle");
  a_tx_ready_clear: assert property (data_wr |=> !tx_ready && !tx_empty_a)
    else $error("ready or empty still high after data write");
  a_owed_char: assert property (hold_ok_reg && !tx_allowed && tx_tick && tx_idle |=>
      tx_act_reg && !tx_fill_reg)
    else $error("owed character not sent after disable");

  // Receiver
  uhtrc_rx_st_t rx_st_reg;
  uhtrc_rx_st_t rx_st_next;
  logic [5:0] rx_cnt_reg;
  logic [5:0] rx_cnt_next;
  logic [3:0] rx_idx_reg;
  logic [3:0] rx_idx_next;
  logic [7:0] rx_sh_reg;
  logic [7:0] rx_sh_next;
  logic rx_par_reg;
  logic rx_par_next;
  logic rx_last_reg;
  logic rx_init_reg;
  logic pe_reg;
  logic fe_reg;
  logic oe_reg;
  logic [7:0] rx_hold_reg;
  logic rx_hold_v_reg;
  logic rx_ready_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  wire rxc_rise = rx_bit_clock & ~rxc_prev_reg;
  wire [5:0] half = div_max >> 1;
  wire rx_smp = rxc_rise & (rx_st_reg == RX_BITS) & (rx_cnt_reg == div_max);
  wire [3:0] last_idx = nd + {3'h0, mode_reg.par_en} - {3'h0, ~async_m};
  wire rx_end = rx_smp & (rx_idx_reg == last_idx);
  wire is_data = rx_idx_reg < nd;
  wire is_par = mode_reg.par_en & (rx_idx_reg == nd);
  wire [7:0] bit_mask = (is_data & rxd) ? (8'h01 << rx_idx_reg) : 8'h00;
  wire [7:0] rx_char = rx_sh_reg | bit_mask;
  wire par_bad = rx_smp & is_par & (rx_par_reg ^ rxd ^ ~mode_reg.even);
  wire frm_bad = rx_end & async_m & ~rxd;
  wire rx_push = rx_end & cmd_reg.rx_en;
  // No room downstream: the new character is dropped and flagged
  wire rx_lost = rx_push & ~fifo_in_ready;
  wire fifo_pop_ok = ~rx_hold_v_reg | data_rd;
  wire rx_hold_v_next = (fifo_out_valid & fifo_pop_ok) | (rx_hold_v_reg & ~data_rd);
  wire rx_init_next = rx_init_reg | (rxc_rise & cmd_reg.rx_en & async_m & rxd &
                                     (rx_st_reg == RX_WAIT1));

  always_comb begin
    rx_st_next = rx_st_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_idx_next = rx_idx_reg;
    rx_sh_next = rx_sh_reg;
    rx_par_next = rx_par_reg;
    if (!cmd_reg.rx_en) begin
      rx_st_next = rx_init_reg ? RX_HUNT : RX_WAIT1;
    end else if (rxc_rise) begin
      case (rx_st_reg)
        RX_WAIT1, RX_HUNT: begin
          rx_cnt_next = 6'h00;
          rx_idx_next = 4'h0;
          rx_sh_next = 8'h00;
          rx_par_next = 1'b0;
          if (!async_m) begin
            rx_st_next = RX_BITS;
          end else if (rx_st_reg == RX_WAIT1) begin
            rx_st_next = rxd ? RX_HUNT : RX_WAIT1;
          end else if (rx_last_reg & ~rxd) begin
            rx_st_next = (div_max == DIV1_MAX) ? RX_BITS : RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_reg == half) begin
            rx_cnt_next = 6'h00;
            rx_st_next = rxd ? RX_HUNT : RX_BITS;
          end else begin
            rx_cnt_next = rx_cnt_reg + 6'h01;
          end
        end
        RX_BITS: begin
          if (rx_cnt_reg != div_max) begin
            rx_cnt_next = rx_cnt_reg + 6'h01;
          end else begin
            rx_cnt_next = 6'h00;
            rx_idx_next = rx_idx_reg + 4'h1;
            rx_sh_next = rx_char;
            rx_par_next = rx_par_reg ^ (is_data & rxd);
            if (rx_end) begin
              rx_st_next = async_m ? RX_HUNT : RX_BITS;
              rx_idx_next = 4'h0;
              rx_sh_next = 8'h00;
              rx_par_next = 1'b0;
            end
          end
        end
        default: rx_st_next = RX_WAIT1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      rx_st_reg <= RX_WAIT1;
      rx_cnt_reg <= 6'h00;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_par_reg <= 1'b0;
      rx_last_reg <= 1'b0;
      rx_init_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      oe_reg <= 1'b0;
      rx_hold_v_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_idx_reg <= rx_idx_next;
      rx_sh_reg <= rx_sh_next;
      rx_par_reg <= rx_par_next;
      rx_last_reg <= rxc_rise ? rxd : rx_last_reg;
      rx_init_reg <= rx_init_next;
      pe_reg <= par_bad | (pe_reg & ~err_clr);
      fe_reg <= frm_bad | (fe_reg & ~err_clr);
      oe_reg <= rx_lost | (oe_reg & ~err_clr);
      rx_hold_v_reg <= rx_hold_v_next;
      rx_ready_reg <= rx_hold_v_next & cmd_next.rx_en;
    end
  end

  always_ff @(posedge clk) begin
    if (fifo_out_valid & fifo_pop_ok) begin
      rx_hold_reg <= fifo_out_data;
    end
  end

  uhtrc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rx_fifo (
    .clk(clk),
    .reset(rst_all),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_char),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop_ok),
    .out_data(fifo_out_data)
  );

  a_false_start: assert property (rx_st_reg == RX_START && rxc_rise && cmd_reg.rx_en &&
      rx_cnt_reg == half && rxd |=> rx_st_reg == RX_HUNT)
    else $error("noise start not rejected at centre");
  a_rx_ready_clear: assert property (data_rd && !fifo_out_valid |=> !rx_ready)
    else $error("receiver ready survived data read");
  a_frame_flag: assert property (frm_bad && !soft_rst |=> fe_reg)
    else $error("missing stop bit not flagged");

  // Status and read path; bus is driven one clock after the read strobe
  wire uhtrc_stat_t status = '{dsr: ~dsr_n, syndet: 1'b0, fe: fe_reg, oe: oe_reg,
                               pe: pe_reg, tx_empty_flag: tx_empty_reg,
                               rx_ready: rx_ready_reg, tx_ready: ~hold_full_reg};
  wire [7:0] rd_mux = c_d ? status : rx_hold_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      data_out_reg <= 8'h00;
      data_oe_n_reg <= 1'b1;
    end else begin
      data_out_reg <= rd_act ? rd_mux : 8'h00;
      data_oe_n_reg <= ~rd_act;
    end
  end

  a_bus_float: assert property (cs_n |=> data_oe_n)
    else $error("bus driven while deselected");
  a_status_read: assert property (rd_act && c_d |=> !data_oe_n &&
      data_out == $past(status))
    else $error("status read returned wrong byte");
  a_reset_idle: assert property ($fell(reset) |-> txd && !tx_ready && !rx_ready &&
      tx_empty_a && dtr_n && rts_n && data_oe_n)
    else $error("outputs not idle after reset");

  c_tx_char: cover property (tx_load ##[1:1000] tx_done);
  c_rx_char: cover property (rx_push && fifo_in_ready);
  c_frame_err: cover property (frm_bad);
  c_sync_fill: cover property (tx_filler);

  assign data_out = data_out_reg;
  assign data_oe_n = data_oe_n_reg;
  assign txd = txd_reg;
  assign dtr_n = dtr_n_reg;
  assign rts_n = rts_n_reg;
  assign tx_ready = tx_ready_reg;
  assign rx_ready = rx_ready_reg;
  assign tx_empty_a = tx_empty_reg;
endmodule : uhtrc_core

// ### bench/uhtrc_far.sv
`timescale 1ns/1ns
module uhtrc_far
  import uhtrc_pkg::*;
#(
  parameter int HALF = 20
) (
  input wire logic clk,
  output logic bit_clk,
  input wire logic txd,
  output logic rxd,
  output logic [7:0] got_byte,
  output logic got_par,
  output logic got_stop,
  output int got_cnt
);
  int div = 0;
  // Bit clock periods per bit; the bench raises it for the 16x tests
  int spb = 1;

  // Runs free like a baud generator; 40 clk per bit keeps well above the minimum ratio
  initial begin
    bit_clk = 1'b1;
    rxd = 1'b1;
    got_cnt = 0;
  end

  always @(posedge clk) begin
    if (div == HALF - 1) begin
      div <= 0;
      bit_clk <= ~bit_clk;
    end else begin
      div <= div + 1;
    end
  end

  // Mid-bit sampling when spb is 1: the device shifts on the fall, so the rise sits in the bit centre
  always begin : watch
    logic [9:0] sh;
    @(posedge bit_clk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 10; i++) begin
        repeat (spb) @(posedge bit_clk);
        sh[i] = txd;
      end
      got_byte = sh[7:0];
      got_par = sh[8];
      got_stop = sh[9];
      got_cnt++;
    end
  end

  // Even parity, one stop bit; the line returns to mark once the frame is done
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] fr;
    fr = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      repeat (spb) @(negedge bit_clk);
      rxd <= fr[i];
    end
    repeat (spb) @(negedge bit_clk);
    rxd <= 1'b1;
  endtask : send

  // Low blip far shorter than half a 16x bit; the centre check must drop it
  task automatic glitch;
    @(negedge bit_clk);
    rxd <= 1'b0;
    repeat (3) @(negedge bit_clk);
    rxd <= 1'b1;
    repeat (200) @(negedge bit_clk);
  endtask : glitch
endmodule : uhtrc_far

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench
  import uhtrc_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, c_d = 1'b0;
  logic cts_n = 1'b1, dsr_n = 1'b0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out, got_byte, rb;
  logic data_oe_n, bit_clk, txd, rxd, dtr_n, rts_n, tx_ready, rx_ready, tx_empty_a;
  logic got_par, got_stop;
  int got_cnt, lows;
  int err_count = 0;
  int n_checks = 0;

  always #50 clk = ~clk;

  uhtrc_core u_dut (.clk(clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .c_d(c_d), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .tx_bit_clock(bit_clk), .rx_bit_clock(bit_clk), .txd(txd), .rxd(rxd), .cts_n(cts_n),
    .dsr_n(dsr_n), .dtr_n(dtr_n), .rts_n(rts_n), .tx_ready(tx_ready), .rx_ready(rx_ready),
    .tx_empty_a(tx_empty_a));

  uhtrc_far u_far (.clk(clk), .bit_clk(bit_clk), .txd(txd), .rxd(rxd),
    .got_byte(got_byte), .got_par(got_par), .got_stop(got_stop), .got_cnt(got_cnt));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Entered and left on a rising edge; strobe idles one clk so the edge detect rearms
  task automatic bus_wr(input logic cd, input logic [7:0] d);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    c_d <= cd;
    data_in <= d;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
  endtask : bus_wr

  task automatic bus_rd(input logic cd, output logic [7:0] d);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    c_d <= cd;
    repeat (2) @(posedge clk);
    #1;
    d = data_out;
    chk({7'h00, data_oe_n}, 8'h00);
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : bus_rd

  task automatic wait_frame(input int n, input logic [7:0] exp);
    for (int i = 0; i < 9000 && got_cnt < n; i++)
      @(posedge clk);
    chk(8'(got_cnt), 8'(n));
    chk({got_stop, got_par, 6'h00}, {1'b1, ^exp, 6'h00});
    chk(got_byte, exp);
  endtask : wait_frame

  task automatic rx_status(input logic [7:0] d, input logic bp, input logic bs,
                           input logic [7:0] exp);
    u_far.send(d, bp, bs);
    for (int i = 0; i < 400 && rx_ready !== 1'b1; i++)
      @(posedge clk);
    chk({7'h00, rx_ready}, 8'h01);
    bus_rd(1'b1, rb);
    chk(rb & 8'h2A, exp);
    bus_rd(1'b0, rb);
    chk(rb, d);
    chk({7'h00, rx_ready}, 8'h00);
  endtask : rx_status

  initial begin
    #5_000_000;
    err_count++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk({txd, tx_empty_a, dtr_n, rts_n, data_oe_n, tx_ready, rx_ready, 1'b0}, 8'hF8);
    @(posedge clk);
    bus_wr(1'b1, 8'h7D);
    bus_wr(1'b1, 8'h26);
    chk({6'h00, dtr_n, rts_n}, 8'h00);
    bus_rd(1'b1, rb);
    chk(rb, 8'h85);
    chk({7'h00, tx_ready}, 8'h00);
    dsr_n <= 1'b1;
    @(posedge clk);
    bus_rd(1'b1, rb);
    chk(rb, 8'h05);
    // Strobes while deselected must neither drive the bus nor load a character
    rd_n <= 1'b0;
    repeat (3) @(posedge clk);
    rd_n <= 1'b1;
    wr_n <= 1'b0;
    data_in <= 8'hFF;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({6'h00, data_oe_n, tx_empty_a}, 8'h03);
    @(posedge clk);
    bus_wr(1'b1, 8'h27);
    chk({7'h00, tx_ready}, 8'h00);
    bus_wr(1'b0, 8'hA5);
    chk({7'h00, tx_empty_a}, 8'h00);
    bus_rd(1'b1, rb);
    chk(rb & 8'h01, 8'h00);
    lows = 0;
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (txd !== 1'b1)
        lows++;
    end
    chk({7'h00, lows != 0}, 8'h00);
    cts_n <= 1'b0;
    wait_frame(1, 8'hA5);
    repeat (100) @(posedge clk);
    #1;
    chk({5'h00, txd, tx_empty_a, tx_ready}, 8'h07);
    @(posedge clk);
    // Two characters queued, then the transmitter is switched off under them
    bus_wr(1'b0, 8'hC3);
    // A second write before the first moves to the shifter would overwrite it
    for (int i = 0; i < 100 && tx_ready !== 1'b1; i++)
      @(posedge clk);
    chk({7'h00, tx_ready}, 8'h01);
    bus_wr(1'b0, 8'h81);
    repeat (150) @(posedge clk);
    bus_wr(1'b1, 8'h26);
    wait_frame(2, 8'hC3);
    wait_frame(3, 8'h81);
    repeat (100) @(posedge clk);
    #1;
    chk({6'h00, txd, tx_empty_a}, 8'h03);
    @(posedge clk);
    rx_status(8'h3C, 1'b0, 1'b0, 8'h02);
    rx_status(8'h5A, 1'b1, 1'b0, 8'h0A);
    bus_wr(1'b1, 8'h36);
    rx_status(8'h96, 1'b0, 1'b1, 8'h22);
    // Soft reset, then the next control write is a mode word again: 16x factor
    bus_wr(1'b1, 8'h40);
    chk({5'h00, dtr_n, rts_n, tx_ready}, 8'h06);
    bus_wr(1'b1, 8'h7E);
    bus_wr(1'b1, 8'h27);
    u_far.spb = 16;
    bus_wr(1'b0, 8'h69);
    wait_frame(4, 8'h69);
    rx_status(8'h4B, 1'b0, 1'b0, 8'h02);
    u_far.glitch();
    chk({7'h00, rx_ready}, 8'h00);
    close_out();
  end
endmodule : testbench
